/* File: logic/tsm_defs.svh */
// Constants for the superframe marker block: frame count, counter width and reset value.
// Assumes inclusion by the package and the design file by bare name.
`ifndef TSM_DEFS_SVH
`define TSM_DEFS_SVH
`define TSM_FRAMES_PER_SUPERFRAME 96
`define TSM_CNT_W                 7
`define TSM_CNT_RESET             7'h00
`endif

/* File: logic/tsm_marker.sv */
// Superframe marker logic for the time-division serial link.
// Assumes the frame syncs, incoming marker and mode straps are synchronous to
// port_bit_clock, driven by the outside frame controller.
`timescale 1ns/1ps
`include "tsm_defs.svh"

module tsm_marker
  import tsm_pkg::*;
#(
  parameter int FRAMES = `TSM_FRAMES_PER_SUPERFRAME
) (
  input  wire logic clk_i,                      // System clock, 100 MHz
  input  wire logic resetn_i,                   // Asynchronous reset, active low
  input  wire logic port_bit_clock,             // Link bit clock
  input  wire logic long_format_i,              // 1: long frame sync, 0: short
  input  wire logic tx_marker_is_input_i,       // 1: transmit marker is an input pin
  input  wire logic tx_frame_sync_i,            // Transmit frame sync
  input  wire logic rx_frame_sync_i,            // Receive frame sync
  input  wire logic tx_superframe_marker_i,     // Transmit marker, input direction
  output logic      tx_superframe_marker_o,     // Transmit marker, output direction
  output logic      tx_superframe_marker_oe_o,  // Transmit marker pin drive enable
  output logic      rx_superframe_marker_o,     // Receive marker output
  output logic      tx_superframe_seen_o        // Pulses for one clk_i cycle on each captured marker
);

  // Link-side straps and syncs sampled on the bit clock
  logic     long_s1, long_s2, dir_s1, dir_s2;
  logic     fsx_q, fsr_q;
  tsm_cnt_t tx_cnt, rx_cnt;
  logic     tx_short_pend, rx_short_pend;
  logic     cap_toggle;
  logic     fsx_rise, fsr_rise;
  logic     tx_first, rx_first;

  always_ff @(posedge port_bit_clock or negedge resetn_i) begin
    if (!resetn_i) begin
      long_s1 <= 1'b0;
      long_s2 <= 1'b0;
      dir_s1  <= 1'b0;
      dir_s2  <= 1'b0;
    end else begin
      long_s1 <= long_format_i;
      long_s2 <= long_s1;
      dir_s1  <= tx_marker_is_input_i;
      dir_s2  <= dir_s1;
    end
  end

  assign fsx_rise = tx_frame_sync_i & ~fsx_q;
  assign fsr_rise = rx_frame_sync_i & ~fsr_q;
  assign tx_first = (tx_cnt == `TSM_CNT_RESET);
  assign rx_first = (rx_cnt == `TSM_CNT_RESET);

  always_ff @(posedge port_bit_clock or negedge resetn_i) begin
    if (!resetn_i) begin
      fsx_q <= 1'b0;
      fsr_q <= 1'b0;
    end else begin
      fsx_q <= tx_frame_sync_i;
      fsr_q <= rx_frame_sync_i;
    end
  end

  // Frame counters; each wraps to zero after FRAMES frame sync rises
  always_ff @(posedge port_bit_clock or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_cnt <= `TSM_CNT_RESET;
      rx_cnt <= `TSM_CNT_RESET;
    end else begin
      if (fsx_rise) begin
        if (tx_cnt == tsm_cnt_t'(FRAMES - 1))
          tx_cnt <= `TSM_CNT_RESET;
        else
          tx_cnt <= tx_cnt + 7'h01;
      end
      if (fsr_rise) begin
        if (rx_cnt == tsm_cnt_t'(FRAMES - 1))
          rx_cnt <= `TSM_CNT_RESET;
        else
          rx_cnt <= rx_cnt + 7'h01;
      end
    end
  end

  // Driven markers: long format follows the sync, short format one pulse late
  always_ff @(posedge port_bit_clock or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_short_pend          <= 1'b0;
      rx_short_pend          <= 1'b0;
      tx_superframe_marker_o <= 1'b0;
      rx_superframe_marker_o <= 1'b0;
    end else begin
      // Transmit marker only pulses while the pin is ours to drive
      tx_short_pend <= fsx_rise & tx_first & ~long_s2 & ~dir_s2;
      rx_short_pend <= fsr_rise & rx_first & ~long_s2;
      if (long_s2) begin
        // Held high for the whole frame sync of the first frame
        tx_superframe_marker_o <= tx_frame_sync_i & ~dir_s2 &
                                  (fsx_rise ? tx_first : tx_superframe_marker_o);
        rx_superframe_marker_o <= rx_frame_sync_i & (fsr_rise ? rx_first : rx_superframe_marker_o);
      end else begin
        tx_superframe_marker_o <= tx_short_pend;
        rx_superframe_marker_o <= rx_short_pend;
      end
    end
  end

  always_ff @(posedge port_bit_clock or negedge resetn_i) begin
    if (!resetn_i)
      tx_superframe_marker_oe_o <= 1'b0;
    else
      tx_superframe_marker_oe_o <= ~dir_s2;
  end

  // Incoming marker capture; short format samples on the falling edge
  logic short_arm, short_hit;
  always_ff @(negedge port_bit_clock or negedge resetn_i) begin
    if (!resetn_i) begin
      short_arm <= 1'b0;
      short_hit <= 1'b0;
    end else begin
      short_arm <= fsx_rise & ~short_arm;
      // First falling edge after the sync is asserted
      short_hit <= ~short_arm & fsx_rise & tx_superframe_marker_i & dir_s2 & ~long_s2;
    end
  end

  always_ff @(posedge port_bit_clock or negedge resetn_i) begin
    if (!resetn_i)
      cap_toggle <= 1'b0;
    else if ((long_s2 & dir_s2 & fsx_rise & tx_superframe_marker_i) | short_hit)
      cap_toggle <= ~cap_toggle;
  end

  // Event crossing into clk_i by toggle; first stage read only by the second
  logic tog_s1, tog_s2, tog_s3;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tog_s1               <= 1'b0;
      tog_s2               <= 1'b0;
      tog_s3               <= 1'b0;
      tx_superframe_seen_o <= 1'b0;
    end else begin
      tog_s1               <= cap_toggle;
      tog_s2               <= tog_s1;
      tog_s3               <= tog_s2;
      tx_superframe_seen_o <= tog_s2 ^ tog_s3;
    end
  end

endmodule

/* File: logic/tsm_pkg.sv */
// Types shared by the superframe marker block.
// Assumes the constants header is on the include path.
`include "tsm_defs.svh"
package tsm_pkg;
  typedef logic [`TSM_CNT_W-1:0] tsm_cnt_t;
endpackage

/* File: verification/testbench.sv */
// Self-checking bench: each format with the marker pin in and out.
// Assumes the frame controller model and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, bclk = 0, resetn_i = 0, lf = 0, inp = 0;
  logic fs, mk, txo, oe, rxo, seen;
  int   miscompares = 0, n_compared = 0, ntx, nrx, nsn;
  always #5 clk_i = ~clk_i;
  always #6 bclk = ~bclk;
  always @(posedge txo) ntx++;
  always @(posedge rxo) nrx++;
  always @(posedge clk_i) if (seen === 1'b1) nsn++;
  tsm_frame_ctl #(.FRAMES(8)) i_tsm_frame_ctl (.bclk_i(bclk), .resetn_i(resetn_i),
    .fs_o(fs), .mk_o(mk));
  // Pin resolves to the device while it drives, else the controller
  tsm_marker #(.FRAMES(8)) i_tsm_marker (.clk_i(clk_i), .resetn_i(resetn_i),
    .port_bit_clock(bclk), .long_format_i(lf), .tx_marker_is_input_i(inp),
    .tx_frame_sync_i(fs), .rx_frame_sync_i(fs), .tx_superframe_marker_i(oe ? txo : mk),
    .tx_superframe_marker_o(txo), .tx_superframe_marker_oe_o(oe),
    .rx_superframe_marker_o(rxo), .tx_superframe_seen_o(seen));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Two superframes of eight frames each per run
  task automatic run(input logic l, input logic i);
    @(negedge clk_i);
    resetn_i = 0;
    lf = l;
    inp = i;
    repeat (3) @(negedge clk_i);
    ntx = 0;
    nrx = 0;
    nsn = 0;
    resetn_i = 1;
    repeat (132) @(posedge bclk);
    @(negedge clk_i);
    check(oe, !i);
    check(nrx, 2);
    check(ntx, i ? 0 : 2);
    check(nsn, i ? 2 : 0);
    $display("test long=%0d input=%0d done", l, i);
  endtask
  initial begin
    run(1, 0);
    run(1, 1);
    run(0, 0);
    run(0, 1);
    wrap_up();
  end
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule

/* File: verification/tsm_frame_ctl.sv */
// Frame controller model: both frame syncs and the incoming marker.
// Assumes a free-running bit clock and the shared active-low reset.
`timescale 1ns/1ps
module tsm_frame_ctl #(parameter int FRAMES = 96) (
  input  wire logic bclk_i,   // Bit clock
  input  wire logic resetn_i, // Reset, active low
  output logic      fs_o,     // Frame sync, both directions
  output logic      mk_o      // Incoming transmit marker
);
  int bit_n;
  int frm;
  always @(posedge bclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_n <= 0;
      frm   <= 0;
    end else begin
      bit_n <= (bit_n == 7) ? 0 : bit_n + 1;
      if (bit_n == 7) frm <= (frm == FRAMES - 1) ? 0 : frm + 1;
    end
  end
  // Three clocks high, inside the allowed two to eight
  assign fs_o = bit_n inside {[4:6]};
  assign mk_o = frm == 0 && bit_n inside {[3:6]};
endmodule

/* File: verification/tsm_marker_assertions.sv */
// Checker for the marker outputs, all in the bit clock domain.
// Assumes frame syncs change just after a bit clock rise.
`timescale 1ns/1ps
module tsm_marker_checker #(parameter int FRAMES = 96) (
  input wire logic clk_i, resetn_i, port_bit_clock, long_format_i, tx_marker_is_input_i,
  input wire logic tx_frame_sync_i, rx_frame_sync_i, tx_superframe_marker_i,
  input wire logic tx_superframe_marker_o, tx_superframe_marker_oe_o,
  input wire logic rx_superframe_marker_o, tx_superframe_seen_o
);
  int nt;
  int nr;
  default clocking @(posedge port_bit_clock); endclocking
  default disable iff (!resetn_i);
  always_ff @(posedge port_bit_clock or negedge resetn_i) begin
    if (!resetn_i) begin
      nt <= 0;
      nr <= 0;
    end else begin
      if ($rose(tx_frame_sync_i)) nt <= (nt == FRAMES - 1) ? 0 : nt + 1;
      if ($rose(rx_frame_sync_i)) nr <= (nr == FRAMES - 1) ? 0 : nr + 1;
    end
  end
  property p_tx_mark;
    tx_superframe_marker_oe_o && $rose(tx_frame_sync_i) && nt == 0
      |-> ##[1:3] tx_superframe_marker_o;
  endproperty
  a_tx_mark: assert property (p_tx_mark) else $error("tx marker missing");
  property p_tx_quiet;
    tx_superframe_marker_oe_o && $rose(tx_frame_sync_i) && nt != 0
      |-> !tx_superframe_marker_o [*4];
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("tx marker early");
  property p_rx_mark;
    $rose(rx_frame_sync_i) && nr == 0 |-> ##[1:3] rx_superframe_marker_o;
  endproperty
  a_rx_mark: assert property (p_rx_mark) else $error("rx marker missing");
  property p_rx_quiet;
    $rose(rx_frame_sync_i) && nr != 0 |-> !rx_superframe_marker_o [*4];
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("rx marker early");
  property p_short_one;
    !long_format_i && $rose(rx_superframe_marker_o) |=> !rx_superframe_marker_o;
  endproperty
  a_short_one: assert property (p_short_one) else $error("short marker width");
  property p_long_with;
    long_format_i && $rose(tx_superframe_marker_o) |-> tx_frame_sync_i;
  endproperty
  a_long_with: assert property (p_long_with) else $error("long marker off sync");
  c_tx: cover property ($rose(tx_superframe_marker_o));
  c_long: cover property (long_format_i && $rose(rx_superframe_marker_o));
  c_short: cover property (!long_format_i && $rose(rx_superframe_marker_o));
endmodule
bind tsm_marker tsm_marker_checker #(.FRAMES(FRAMES)) i_tsm_marker_checker (.*);
